// *** hw/spbg_consts.vh ***
/*
 * Constants for the strobe framing and bank-group timing block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 40 MHz system clock and an external memory clock sampled as a pin.
 */
`ifndef SPBG_CONSTS_VH
`define SPBG_CONSTS_VH

// Register byte offsets.
`define SPBG_OFF_CONFIG 8'h00
`define SPBG_OFF_COMMAND 8'h04
`define SPBG_OFF_STATUS 8'h08
`define SPBG_OFF_LATENCY 8'h0c

// Preamble config register fields.
`define SPBG_CFG_TRAIN_BIT 10
`define SPBG_CFG_RPRE_BIT 11
`define SPBG_CFG_WPRE_BIT 12
`define SPBG_CFG_RESET 32'h0000_0000

// Command register fields: [1:0] kind, [3:2] page, [4] wide part.
`define SPBG_CMD_READ 2'h1
`define SPBG_CMD_WRITE 2'h2
`define SPBG_CMD_PAGE_TRAIN 2'h1
`define SPBG_CMD_KIND_LSB 0
`define SPBG_CMD_PAGE_LSB 2
`define SPBG_CMD_WIDE_BIT 4
`define SPBG_CMD_GROUP_LSB 8

// Latency register reset: CAS latency in memory clocks, burst length in beats.
`define SPBG_CL_RESET 8'h0b
`define SPBG_BL_RESET 8'h08

// Strobe drive delay: mode delay in memory clocks plus 9 ns.
`define SPBG_MODE_DELAY_NCK 24
`define SPBG_SDO_EXTRA_NS 9
`define SPBG_CLK_PERIOD_NS 25
// Memory clock period assumed when the mode delay is turned into time.
`define SPBG_NCK_NS 5

// Preamble: half-clock steps spent in the preamble state; the first toggle adds one.
`define SPBG_PRE1_HALVES 8'h01
`define SPBG_PRE2_HALVES 8'h03

// Bank groups.
`define SPBG_GROUPS_X8 4
`define SPBG_GROUPS_X16 2

`endif

// *** hw/spbg_strobe_gen.v ***
/*
 * Strobe sequencer: walks preamble, burst toggles and half-clock postamble
 * for one read or write burst, or parks strobes for preamble training.
 * Assumes mclk_rise and mclk_fall are one-cycle enables from a synchronised clock.
 */
`timescale 1ns/1ps
`include "spbg_consts.vh"

module spbg_strobe_gen (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // Memory clock edge enables.
  input wire mclk_rise,
  input wire mclk_fall,
  // Burst request.
  input wire start,
  input wire two_clk_pre,
  input wire [7:0] beats,
  // Training park.
  input wire park,
  // Strobe outputs.
  output reg dqs_t,
  output reg dqs_c,
  output reg dqs_oe,
  output reg busy,
  output reg post_done
);

  localparam ST_IDLE = 2'd0;
  localparam ST_PRE = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_POST = 2'd3;

  reg [1:0] state_q;
  reg [7:0] cnt_q;

  // Each phase is counted in half memory clocks so the postamble is exactly half a clock.
  always @(posedge aclk) begin
    post_done <= 1'b0;
    if (!aresetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      dqs_t <= 1'b0;
      dqs_c <= 1'b1;
      dqs_oe <= 1'b0;
      busy <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          dqs_t <= 1'b0;
          dqs_c <= 1'b1;
          // The strobe is driven from the start edge so the low preamble lasts whole clocks.
          dqs_oe <= park || start;
          if (start) begin
            busy <= 1'b1;
            state_q <= ST_PRE;
            cnt_q <= two_clk_pre ? `SPBG_PRE2_HALVES : `SPBG_PRE1_HALVES;
          end else begin
            busy <= 1'b0;
          end
        end
        ST_PRE: begin
          dqs_oe <= 1'b1;
          if (mclk_rise || mclk_fall) begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
              state_q <= ST_DATA;
              cnt_q <= beats;
            end
          end
        end
        ST_DATA: begin
          if (mclk_rise || mclk_fall) begin
            dqs_t <= ~dqs_t;
            dqs_c <= dqs_t;
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
              state_q <= ST_POST;
            end
          end
        end
        ST_POST: begin
          // One half clock of postamble, whichever preamble was used.
          if (mclk_rise || mclk_fall) begin
            state_q <= ST_IDLE;
            dqs_t <= 1'b0;
            dqs_c <= 1'b1;
            dqs_oe <= park;
            busy <= 1'b0;
            post_done <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // spbg_strobe_gen

// *** hw/spbg_top.v ***
/*
 * Device-side strobe framing block with an AXI4-Lite register slave: preamble
 * config, burst commands, read preamble training and bank-group decode.
 * Assumes the memory clock arrives as an asynchronous pin slower than aclk.
 */
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "spbg_consts.vh"

module spbg_top (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address.
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data.
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response.
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address.
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data.
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Memory clock pin.
  input wire mem_clk,
  // Strobe and data pins.
  output reg dqs_t_o,
  output reg dqs_c_o,
  output reg dqs_oe,
  output reg [15:0] dq_o,
  output reg dq_oe,
  // Bank group of the last command.
  output reg [1:0] bank_group_select
);

  // Strobe drive delay in whole aclk cycles.
  localparam integer SDO_SUM_NS = `SPBG_MODE_DELAY_NCK * `SPBG_NCK_NS + `SPBG_SDO_EXTRA_NS;
  localparam integer SDO_CYC_INT = SDO_SUM_NS / `SPBG_CLK_PERIOD_NS;
  // The integer is cut to the counter width on purpose; the count is far below it.
  localparam [15:0] SDO_CYCLES_RAW = SDO_CYC_INT[15:0];
  // A zero count would skip the delay altogether, so at least one cycle is kept.
  localparam [15:0] SDO_CYCLES = (SDO_CYCLES_RAW == 16'h0000) ? 16'h0001 : SDO_CYCLES_RAW;

  // Register state.
  reg [31:0] preamble_config_register_q;
  reg [7:0] cas_lat_q;
  reg [7:0] burst_len_q;
  reg wide_q;
  reg [1:0] page_q;
  reg cmd_pend_q;
  reg cmd_read_q;
  reg [7:0] cl_cnt_q;
  reg [15:0] sdo_cnt_q;
  reg sdo_ok_q;
  reg [15:0] bursts_q;

  // Memory clock synchroniser and edge detect. Only the second stage feeds logic;
  // the third exists for edge detection. All stages reset low, the pin's idle
  // level, so no false edge follows reset.
  reg mclk_s1_q;
  reg mclk_s2_q;
  reg mclk_s3_q;
  wire mclk_rise = mclk_s2_q & ~mclk_s3_q;
  wire mclk_fall = ~mclk_s2_q & mclk_s3_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      mclk_s1_q <= 1'b0;
      mclk_s2_q <= 1'b0;
      mclk_s3_q <= 1'b0;
    end else begin
      mclk_s1_q <= mem_clk;
      mclk_s2_q <= mclk_s1_q;
      mclk_s3_q <= mclk_s2_q;
    end
  end

  wire training = preamble_config_register_q[`SPBG_CFG_TRAIN_BIT];
  wire rpre_two = preamble_config_register_q[`SPBG_CFG_RPRE_BIT];
  wire wpre_two = preamble_config_register_q[`SPBG_CFG_WPRE_BIT];

  // Write channel: address and data taken in either order, response after both.
  // Ready is a one-cycle pulse, so a master that holds valid on is never taken twice.
  reg aw_got_q;
  reg w_got_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  wire start_burst;
  wire gen_busy;

  // Command word fields, named once so the decode below reads plainly.
  wire [1:0] cmd_kind = w_data_q[`SPBG_CMD_KIND_LSB +: 2];
  wire [1:0] cmd_page = w_data_q[`SPBG_CMD_PAGE_LSB +: 2];
  wire cmd_wide = w_data_q[`SPBG_CMD_WIDE_BIT];
  wire [1:0] cmd_group = w_data_q[`SPBG_CMD_GROUP_LSB +: 2];
  wire cmd_is_read = (cmd_kind == `SPBG_CMD_READ);
  wire cmd_is_write = (cmd_kind == `SPBG_CMD_WRITE);
  // Wide part has one group bit, byte part two; the unused upper bit reads zero.
  wire [1:0] cmd_group_eff = cmd_wide ? {1'b0, cmd_group[0]} : cmd_group;

  // Config bytes whose strobe is clear keep their old value.
  wire [31:0] cfg_merged;
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign cfg_merged[lane*8 +: 8] = w_strb_q[lane] ? w_data_q[lane*8 +: 8] :
        preamble_config_register_q[lane*8 +: 8];
    end
  endgenerate

  // Read-back words; unused bits read as zero so software may mask freely.
  wire [31:0] cmd_word = {22'h0, bank_group_select, 3'h0, wide_q, page_q, cmd_read_q,
    cmd_pend_q};
  wire [31:0] status_word = {bursts_q, 13'h0, sdo_ok_q, gen_busy, training};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      preamble_config_register_q <= `SPBG_CFG_RESET;
      cas_lat_q <= `SPBG_CL_RESET;
      burst_len_q <= `SPBG_BL_RESET;
      wide_q <= 1'b0;
      page_q <= 2'b00;
      cmd_pend_q <= 1'b0;
      cmd_read_q <= 1'b0;
      bank_group_select <= 2'b00;
    end else begin
      s_axi_awready <= !aw_got_q && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !w_got_q && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (start_burst) begin
        cmd_pend_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (aw_addr_q)
          `SPBG_OFF_CONFIG: begin
            preamble_config_register_q <= cfg_merged;
          end
          `SPBG_OFF_COMMAND: begin
            // Commands are refused while a burst is pending or running.
            if (!cmd_pend_q && !gen_busy) begin
              // Codes other than read and write are taken but start nothing.
              cmd_pend_q <= cmd_is_read || cmd_is_write;
              cmd_read_q <= cmd_is_read;
              page_q <= cmd_page;
              wide_q <= cmd_wide;
              bank_group_select <= cmd_group_eff;
            end else begin
              s_axi_bresp <= 2'b10;
            end
          end
          `SPBG_OFF_LATENCY: begin
            cas_lat_q <= w_data_q[7:0];
            burst_len_q <= w_data_q[15:8];
          end
          default: begin
            s_axi_bresp <= 2'b10;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address to data.
  // Read data stand until taken; a further address waits until then.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `SPBG_OFF_CONFIG: s_axi_rdata <= preamble_config_register_q;
          `SPBG_OFF_COMMAND: s_axi_rdata <= cmd_word;
          `SPBG_OFF_STATUS: s_axi_rdata <= status_word;
          `SPBG_OFF_LATENCY: s_axi_rdata <= {16'h0, burst_len_q, cas_lat_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Strobe drive delay after training is enabled; strobes are driven at once.
  always @(posedge aclk) begin
    if (!aresetn || !training) begin
      sdo_cnt_q <= 16'h0000;
      sdo_ok_q <= 1'b0;
    end else if (sdo_cnt_q < SDO_CYCLES) begin
      sdo_cnt_q <= sdo_cnt_q + 16'h0001;
    end else begin
      sdo_ok_q <= 1'b1;
    end
  end

  // CAS latency count before the strobe sequence, in memory clocks.
  // The burst starts on the memory clock rise after the count runs out, so the
  // preamble always begins on a rising edge and its length is whole clocks.
  // In training only a page-1 read starts strobes; other reads are dropped.
  wire cmd_ok = !training || (cmd_read_q && page_q == `SPBG_CMD_PAGE_TRAIN);
  always @(posedge aclk) begin
    if (!aresetn) begin
      cl_cnt_q <= 8'h00;
    end else if (!cmd_pend_q) begin
      cl_cnt_q <= cas_lat_q;
    end else if (mclk_rise && cl_cnt_q != 8'h00) begin
      cl_cnt_q <= cl_cnt_q - 8'h01;
    end
  end
  assign start_burst = cmd_pend_q && cl_cnt_q == 8'h00 && mclk_rise;

  // Sequencer outputs, registered once more at the pins below.
  wire g_t;
  wire g_c;
  wire g_oe;
  wire g_done;

  spbg_strobe_gen u_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .mclk_rise(mclk_rise),
    .mclk_fall(mclk_fall),
    .start(start_burst && cmd_ok),
    .two_clk_pre(cmd_read_q ? rpre_two : wpre_two),
    .beats(burst_len_q),
    .park(training),
    .dqs_t(g_t),
    .dqs_c(g_c),
    .dqs_oe(g_oe),
    .busy(gen_busy),
    .post_done(g_done)
  );

  // Pin registers; data always held high, driven in training and during read bursts.
  always @(posedge aclk) begin
    if (!aresetn) begin
      dqs_t_o <= 1'b0;
      dqs_c_o <= 1'b1;
      dqs_oe <= 1'b0;
      dq_o <= 16'hffff;
      dq_oe <= 1'b0;
    end else begin
      dqs_t_o <= g_t;
      dqs_c_o <= g_c;
      dqs_oe <= g_oe;
      dq_o <= 16'hffff;
      dq_oe <= training || (gen_busy && cmd_read_q);
    end
  end

  // Finished bursts, counted at each postamble end; the count wraps silently,
  // so software compares two readings rather than trusting the absolute value.
  always @(posedge aclk) begin
    if (!aresetn) begin
      bursts_q <= 16'h0000;
    end else if (g_done) begin
      bursts_q <= bursts_q + 16'h0001;
    end
  end

endmodule // spbg_top

// *** tb/spbg_monitor.sv ***
/* Checker for the strobe framing block's pins and register bus.
   Assumes it is bound to spbg_top and sees only its ports. */
`timescale 1ns/1ps
module spbg_monitor (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus handshakes.
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Strobe and data pins.
  input wire logic dqs_t_o,
  input wire logic dqs_c_o,
  input wire logic dqs_oe,
  input wire logic dq_oe,
  input wire logic [15:0] dq_o
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  dq_quiet_a: assert property (dq_o == 16'hffff)
    else $error("data lines not held high");
  strobe_pair_a: assert property (dqs_oe |-> dqs_c_o != dqs_t_o)
    else $error("strobe pair not complementary");
  strobe_rise_a: assert property ($rose(dqs_t_o) |-> dqs_oe)
    else $error("strobe toggled while released");
  post_low_a: assert property ($fell(dqs_oe) |->
    !$past(dqs_t_o) && !$past(dqs_t_o, 2) && !$past(dqs_t_o, 3))
    else $error("postamble too short");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Main scenarios: a burst release, a read or training burst, a refused write.
  cover property ($fell(dqs_oe));
  cover property (dq_oe && $rose(dqs_t_o));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // spbg_monitor
bind spbg_top spbg_monitor i_mon (.*);

// *** tb/spbg_ctrl_model.sv ***
/* Memory controller model: drives the memory clock, times the strobe.
   Assumes the device drives the strobe pins with an output enable. */
`timescale 1ns/1ps
module spbg_ctrl_model (
  // Memory clock.
  output logic mem_clk,
  // Strobe pins seen.
  input wire logic dqs_t_o,
  input wire logic dqs_oe,
  // Measured preamble and postamble in ns.
  output int pre_ns,
  output int post_ns
);
  realtime t_on, t_fall;
  bit first;
  initial begin
    mem_clk = 1'b0;
    pre_ns = 0;
    post_ns = 0;
  end
  // The controller's clock runs free.
  always #100 mem_clk = ~mem_clk;
  // Preamble lasts from drive-on to the first strobe rise.
  always @(posedge dqs_oe) begin
    t_on = $realtime;
    first = 1'b1;
  end
  always @(posedge dqs_t_o) if (first) begin
    pre_ns = int'($realtime - t_on);
    first = 1'b0;
  end
  // Postamble lasts from the last strobe fall to release.
  always @(negedge dqs_t_o) t_fall = $realtime;
  always @(negedge dqs_oe) post_ns = int'($realtime - t_fall);
endmodule // spbg_ctrl_model

// *** tb/tb_spbg_top.sv ***
/* Testbench for spbg_top: register bus master and scenario tasks.
   Assumes the controller model and the bound checker. */
`timescale 1ns/1ps
module tb_spbg_top;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, mem_clk, dqs_t_o, dqs_c_o, dqs_oe, dq_oe;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, cnt;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, bank_group_select, rsp;
  logic [15:0] dq_o;
  int pre_ns, post_ns, n_fail = 0, samples_checked = 0, cyc = 0;
  spbg_top i_dut (.*);
  spbg_ctrl_model i_ctrl (.*);
  always #12.5 aclk = ~aclk;
  // A hang is cut short well beyond the expected run.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Write one word; address and data are offered together, each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Wait until no command is pending, then until the sequencer is idle; leaves status in rd.
  task automatic idle();
    do begin
      rdr(8'h04);
    end while (rd[0] !== 1'b0);
    do begin
      rdr(8'h08);
    end while (rd[1] !== 1'b0);
  endtask
  task automatic t_regs();
    rdr(8'h00);
    chk("config reset", rd, 32'h0);
    rdr(8'h0c);
    chk("latency reset", rd, 32'h0000080b);
    wr(8'h0c, 32'hffff_0806);
    rdr(8'h0c);
    chk("latency write", rd, 32'h0000_0806);
    rdr(8'h10);
    chk("unmapped read", {29'h0, rsp, rd[31:0] == 32'h0}, {29'h0, 2'h2, 1'b1});
    wr(8'h10, 32'h1);
    chk("unmapped write", {30'h0, rsp}, 32'h2);
    $display("test regs done");
  endtask
  // Commands wait for the previous burst, far past any spacing.
  task automatic burst(input logic [31:0] cfg, cmd, input int pre, input logic [1:0] grp);
    rdr(8'h08);
    cnt = rd;
    wr(8'h00, cfg);
    wr(8'h04, cmd);
    idle();
    chk("burst count", rd[31:16], cnt[31:16] + 16'h1);
    chk("preamble", 32'(pre_ns > pre - 30 && pre_ns < pre + 30), 32'h1);
    chk("postamble", 32'(post_ns > 70 && post_ns < 130), 32'h1);
    chk("group", {30'h0, bank_group_select}, {30'h0, grp});
  endtask
  task automatic t_bursts();
    burst(32'h0, 32'h201, 200, 2'h2);
    burst(32'h800, 32'h301, 400, 2'h3);
    burst(32'h0, 32'h102, 200, 2'h1);
    burst(32'h1000, 32'h312, 400, 2'h1);
    wr(8'h04, 32'h1);
    wr(8'h04, 32'h1);
    chk("busy refusal", {30'h0, rsp}, 32'h2);
    idle();
    $display("test bursts done");
  endtask
  task automatic t_train();
    wr(8'h00, 32'h400);
    repeat (4) @(posedge aclk);
    chk("strobe drive", {30'h0, dqs_oe, dq_oe}, 32'h3);
    chk("parked", {30'h0, dqs_t_o, dqs_c_o}, 32'h1);
    chk("dq quiet", {16'h0, dq_o}, 32'hffff);
    rdr(8'h08);
    cnt = rd;
    chk("training flag", {31'h0, rd[0]}, 32'h1);
    chk("drive delay met", {31'h0, rd[2]}, 32'h1);
    wr(8'h04, 32'h1);
    idle();
    chk("page0 dropped", rd[31:16], cnt[31:16]);
    chk("page0 parked", {31'h0, dqs_t_o}, 32'h0);
    wr(8'h04, 32'h5);
    idle();
    chk("page1 burst", rd[31:16], cnt[31:16] + 16'h1);
    wr(8'h00, 32'h0);
    rdr(8'h08);
    chk("training off", {31'h0, rd[0]}, 32'h0);
    $display("test train done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_bursts();
    t_train();
    complete_run();
  end
endmodule // tb_spbg_top
